// ---- verilog/tape_pkg.sv ----
// Purpose: shared constants, types and state layouts of the tape serializer
// Assumes: 40 MHz system clock, eight register elements plus the output one
// Notes:   long counts except the debounce count are defaults for top-level parameters
package tape_pkg;

   // clock and timing figures in their own units
   localparam int CLK_HZ      = 40_000_000;
   localparam int POR_WAIT_MS = 300;
   localparam int BAUD        = 1050;
   localparam int DEB_TIME_US = 100;

   // derived cycle counts
   localparam int POR_CYCLES      = CLK_HZ / 1000 * POR_WAIT_MS;
   localparam int BIT_CYCLES      = CLK_HZ / BAUD;
   localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
   localparam int STOP_CYCLES     = BIT_CYCLES;
   localparam int DEB_CYCLES      = CLK_HZ / 1_000_000 * DEB_TIME_US;

   // widths
   localparam int CODE_LEVELS = 8;
   localparam int SR_W        = CODE_LEVELS + 1;
   localparam int TMR_W       = 24;
   localparam int DEB_W       = 12;
   localparam int PCNT_W      = 4;

   // one clear pulse, then levels plus stop as advance pulses
   localparam logic [PCNT_W-1:0] LAST_PULSE = 4'h9;

   // level masks: five-level fixed marks, five-level data, eight-level unused
   localparam logic [CODE_LEVELS-1:0] FIVE_FIXED_MARK = 8'hc1;
   localparam logic [CODE_LEVELS-1:0] FIVE_DATA_LVLS  = 8'h3e;
   localparam logic [CODE_LEVELS-1:0] EIGHT_UNUSED    = 8'hc0;

   // reset values
   localparam logic [SR_W-1:0] SR_RESET = 9'h1ff;

   typedef enum logic [1:0] {
      ST_POR  = 2'b00,
      ST_STOP = 2'b01,
      ST_RUN  = 2'b10
   } dist_phase_e;

   typedef struct packed {
      logic [CODE_LEVELS-1:0] mark;
      logic                   univ;
   } reader_s;

   typedef struct packed {
      logic                   pickup_n;
      logic                   motor;
      logic                   high_speed;
      logic                   eight;
      logic [CODE_LEVELS-1:0] used;
   } cfg_pins_s;

   typedef struct packed {
      reader_s                     s1;
      reader_s                     s2;
      reader_s                     stable;
      logic [SR_W-1:0][DEB_W-1:0] cnt;
   } filt_st_s;

   typedef struct packed {
      logic             active;
      logic             done;
      logic [TMR_W-1:0] cnt;
   } shot_st_s;

   typedef struct packed {
      cfg_pins_s         s1;
      cfg_pins_s         s2;
      logic              pick_prev;
      dist_phase_e       phase;
      logic [TMR_W-1:0]  por_cnt;
      logic              por_pulse;
      logic [TMR_W-1:0]  tick_cnt;
      logic [PCNT_W-1:0] pulse_cnt;
      logic [SR_W-1:0]   sr;
      logic              line;
      logic              rts;
   } dist_st_s;

endpackage : tape_pkg

// ---- verilog/contact_filter.sv ----
// Purpose: synchronise and debounce the reader mark and universal contacts
// Assumes: contacts are pins, outside the clock domain
// Notes:   a change must hold for the debounce time before it is accepted
`timescale 1ns/1ps
`default_nettype none
module contact_filter (
   // clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // contacts
   input  wire tape_pkg::reader_s raw_i,
   output var  tape_pkg::reader_s clean_o
);
   localparam int W = tape_pkg::SR_W;
   localparam int unsigned LASTV = tape_pkg::DEB_CYCLES - 1;
   localparam logic [tape_pkg::DEB_W-1:0] DEB_LAST =
      LASTV[tape_pkg::DEB_W-1:0];

   tape_pkg::filt_st_s q_reg;
   tape_pkg::filt_st_s q_next;
   logic [W-1:0]       s2_bits;
   logic [W-1:0]       st_bits;
   logic [W-1:0]       st_next;

   assign s2_bits = q_reg.s2;
   assign st_bits = q_reg.stable;

   always_comb begin
      q_next    = q_reg;
      st_next   = st_bits;
      q_next.s1 = raw_i;
      q_next.s2 = q_reg.s1;
      // per contact: count while differing, accept at the limit
      for (int k = 0; k < W; k++) begin
         if (s2_bits[k] == st_bits[k]) begin
            q_next.cnt[k] = '0;
         end else if (q_reg.cnt[k] == DEB_LAST) begin
            st_next[k]    = s2_bits[k]; // RULE_13
            q_next.cnt[k] = '0;
         end else begin
            q_next.cnt[k] = q_reg.cnt[k] + 1'b1;
         end
      end
      q_next.stable = st_next;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         q_reg <= '0;
      end else if (ce_i) begin
         q_reg <= q_next;
      end
   end

   assign clean_o = q_reg.stable;

endmodule : contact_filter
`default_nettype wire

// ---- verilog/one_shot.sv ----
// Purpose: retriggerable mono-stable timer with a trailing-edge pulse
// Assumes: trigger is a one-cycle pulse on the same clock
// Notes:   active lasts exactly CYCLES enabled cycles
`timescale 1ns/1ps
`default_nettype none
module one_shot #(
   parameter int unsigned CYCLES = 2
) (
   // clock and reset
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   // timer
   input  wire logic trig_i,
   output logic      active_o,
   output logic      done_o
);
   localparam int TW = tape_pkg::TMR_W;
   localparam int unsigned LOADV = CYCLES - 1;
   localparam logic [TW-1:0] LOAD = LOADV[TW-1:0];

   tape_pkg::shot_st_s q_reg;
   tape_pkg::shot_st_s q_next;

   always_comb begin
      q_next      = q_reg;
      q_next.done = 1'b0;
      if (trig_i) begin
         q_next.active = 1'b1;
         q_next.cnt    = LOAD;
      end else if (q_reg.active) begin
         if (q_reg.cnt == '0) begin
            q_next.active = 1'b0;
            q_next.done   = 1'b1;
         end else begin
            q_next.cnt = q_reg.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         q_reg <= '0;
      end else if (ce_i) begin
         q_reg <= q_next;
      end
   end

   assign active_o = q_reg.active;
   assign done_o   = q_reg.done;

endmodule : one_shot
`default_nettype wire

// ---- verilog/start_stop_tape_serializer.sv ----
// Purpose: sending distributor and converter of a start-stop tape sender
// Assumes: reader contacts, pickup and switches arrive as raw pins
// Notes:   line_drive_o high asks the polar driver for space
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE_01: after power-on wait 300 ms, then one pulse forces the line to mark.
// RULE_02: pickup pulse is shaped, inverted and halts the advance oscillator.
// RULE_03: pickup pulse starts a stop timer about one stop unit long.
// RULE_04: stop timer end, through an open start gate, starts the oscillator.
// RULE_05: start gate is open only while the universal contact is closed.
// RULE_06: with no tape, no oscillator start and the line stays at mark.
// RULE_07: half-bit sample delay from start so the start space comes first.
// RULE_08: at the sample strobe closed contacts set elements, open stay zero.
// RULE_09: first pulse in sample delay clears, later pulses advance.
// RULE_10: output element takes no code bit; clearing it makes the start space.
// RULE_11: each advance shifts the register toward the output, level 0 first.
// RULE_12: ones follow the last bit so the line holds stop until next clear.
// RULE_13: reader contacts are debounced before entering the register.
// RULE_14: serial output is inverted before the line driver.
// RULE_15: request-to-send follows the motor switch, or stays on at high speed.
// RULE_16: five-level frames send level 0 and levels 6, 7 as mark.
// RULE_17: eight-level: unused level 0 is space, unused 6 and 7 are mark.
// RULE_18: per character one clear pulse then nine advance pulses.
// RULE_19: bit ticks come from the system clock, restarted at each start.
module start_stop_tape_serializer #(
   parameter int unsigned POR_CYC  = tape_pkg::POR_CYCLES,
   parameter int unsigned BIT_CYC  = tape_pkg::BIT_CYCLES,
   parameter int unsigned HALF_CYC = tape_pkg::HALF_BIT_CYCLES,
   parameter int unsigned STOP_CYC = tape_pkg::STOP_CYCLES
) (
   // clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   // tape reader
   input  wire logic [7:0] mark_contact_i,
   input  wire logic       univ_contact_i,
   input  wire logic       pickup_n_i,
   // variant and switches
   input  wire logic       eight_level_i,
   input  wire logic [7:0] level_used_i,
   input  wire logic       motor_switch_i,
   input  wire logic       high_speed_i,
   // data set
   output logic            line_drive_o,
   output logic            rts_o,
   // status
   output logic            sample_o,
   output logic            running_o
);
   localparam int TW = tape_pkg::TMR_W;
   localparam int unsigned POR_LV = POR_CYC - 1;
   localparam int unsigned BIT_LV = BIT_CYC - 1;
   localparam logic [TW-1:0] POR_LAST = POR_LV[TW-1:0];
   localparam logic [TW-1:0] BIT_LAST = BIT_LV[TW-1:0];

   tape_pkg::dist_st_s q_reg;
   tape_pkg::dist_st_s q_next;
   tape_pkg::reader_s  raw_rd;
   tape_pkg::reader_s  clean_rd;
   tape_pkg::cfg_pins_s pins;

   logic       pick_lvl;
   logic       pickup_evt;
   logic       stop_active;
   logic       stop_done;
   logic       start_evt;
   logic       sample_active;
   logic       sample_strobe;
   logic       tick;
   logic       clear_p;
   logic       adv_p;
   logic [7:0] code_bits;

   assign raw_rd.mark = mark_contact_i;
   assign raw_rd.univ = univ_contact_i;

   assign pins.pickup_n   = pickup_n_i;
   assign pins.motor      = motor_switch_i;
   assign pins.high_speed = high_speed_i;
   assign pins.eight      = eight_level_i;
   assign pins.used       = level_used_i;

   contact_filter u_filter (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .raw_i     (raw_rd),
      .clean_o   (clean_rd)
   );

   // stop interval, begun by each character pulse after the power-on wait
   one_shot #(
      .CYCLES (STOP_CYC)
   ) u_stop_timer (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .trig_i    (pickup_evt), // RULE_03
      .active_o  (stop_active),
      .done_o    (stop_done)
   );

   // half-bit delay between start space and character sampling
   one_shot #(
      .CYCLES (HALF_CYC)
   ) u_sample_delay (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .trig_i    (start_evt), // RULE_07
      .active_o  (sample_active),
      .done_o    (sample_strobe)
   );

   // code value per level, by variant and used-level straps
   for (genvar k = 0; k < 8; k++) begin : g_level
      always_comb begin
         if (!q_reg.s2.eight) begin
            code_bits[k] = tape_pkg::FIVE_FIXED_MARK[k] |
                           (tape_pkg::FIVE_DATA_LVLS[k] &
                            clean_rd.mark[k]); // RULE_16
         end else if (q_reg.s2.used[k]) begin
            code_bits[k] = clean_rd.mark[k]; // RULE_08
         end else begin
            code_bits[k] = tape_pkg::EIGHT_UNUSED[k]; // RULE_17
         end
      end
   end

   // pickup pin is active low: invert, then take the leading edge
   assign pick_lvl   = ~q_reg.s2.pickup_n; // RULE_02
   assign pickup_evt = pick_lvl & ~q_reg.pick_prev &
                       (q_reg.phase != tape_pkg::ST_POR);

   // start gate held by the universal contact
   assign start_evt = stop_done & clean_rd.univ & ~pickup_evt &
                      (q_reg.phase == tape_pkg::ST_STOP); // RULE_04 RULE_05

   assign tick    = (q_reg.phase == tape_pkg::ST_RUN) &&
                    (q_reg.tick_cnt == '0);
   assign clear_p = tick & sample_active; // RULE_09
   assign adv_p   = tick & ~sample_active; // RULE_09

   always_comb begin
      q_next           = q_reg;
      q_next.s1        = pins;
      q_next.s2        = q_reg.s1;
      q_next.pick_prev = pick_lvl;
      q_next.por_pulse = 1'b0;
      case (q_reg.phase)
         tape_pkg::ST_POR: begin
            if (q_reg.por_cnt == POR_LAST) begin
               q_next.por_pulse = 1'b1; // RULE_01
               q_next.phase     = tape_pkg::ST_STOP;
            end else begin
               q_next.por_cnt = q_reg.por_cnt + 1'b1;
            end
         end
         tape_pkg::ST_STOP: begin
            if (start_evt) begin // RULE_06
               q_next.phase     = tape_pkg::ST_RUN;
               q_next.tick_cnt  = '0; // RULE_19
               q_next.pulse_cnt = '0;
            end
         end
         tape_pkg::ST_RUN: begin
            if (q_reg.tick_cnt == BIT_LAST) begin
               q_next.tick_cnt = '0;
            end else begin
               q_next.tick_cnt = q_reg.tick_cnt + 1'b1; // RULE_19
            end
            if (pickup_evt) begin
               q_next.phase = tape_pkg::ST_STOP; // RULE_02
            end else if (tick) begin
               q_next.pulse_cnt = q_reg.pulse_cnt + 1'b1;
               if (q_reg.pulse_cnt == tape_pkg::LAST_PULSE) begin
                  q_next.phase = tape_pkg::ST_STOP; // RULE_18
               end
            end
         end
         default: begin
            q_next.phase = tape_pkg::ST_POR;
         end
      endcase

      // signal register, index 0 is the output element
      if (q_reg.por_pulse) begin
         q_next.sr[0] = 1'b1; // RULE_01
      end
      if (clear_p) begin
         q_next.sr = '0; // RULE_10
      end else if (adv_p) begin
         q_next.sr = {1'b1, q_reg.sr[8:1]}; // RULE_11 RULE_12
      end
      if (sample_strobe) begin
         q_next.sr[8:1] = q_next.sr[8:1] | code_bits; // RULE_08
      end

      q_next.line = ~q_next.sr[0]; // RULE_14
      q_next.rts  = q_reg.s2.high_speed | q_reg.s2.motor; // RULE_15
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         q_reg       <= '0;
         q_reg.phase <= tape_pkg::ST_POR;
         q_reg.sr    <= tape_pkg::SR_RESET;
         q_reg.s1.pickup_n <= 1'b1;
         q_reg.s2.pickup_n <= 1'b1;
      end else if (ce_i) begin
         q_reg <= q_next;
      end
   end

   assign line_drive_o = q_reg.line;
   assign rts_o        = q_reg.rts;
   assign sample_o     = sample_strobe;
   assign running_o    = (q_reg.phase == tape_pkg::ST_RUN);

   // checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   sequence s_start;
      ce_i && start_evt;
   endsequence

   sequence s_running;
      (q_reg.phase == tape_pkg::ST_RUN) && sample_active;
   endsequence

   property p_por_mark;
      (ce_i && q_reg.por_pulse && !clear_p) |=> q_reg.sr[0];
   endproperty
   a_por_mark: assert property (p_por_mark) // RULE_01
      else $error("reset pulse did not force mark");

   property p_por_pulse;
      (ce_i && q_reg.phase == tape_pkg::ST_POR &&
       q_reg.por_cnt == POR_LAST) |=> q_reg.por_pulse;
   endproperty
   a_por_pulse: assert property (p_por_pulse) // RULE_01
      else $error("no reset pulse after power-on wait");

   property p_pick_halt;
      (ce_i && pickup_evt) |=> (q_reg.phase != tape_pkg::ST_RUN);
   endproperty
   a_pick_halt: assert property (p_pick_halt) // RULE_02
      else $error("pickup pulse did not halt oscillator");

   property p_stop_timer;
      (ce_i && pickup_evt) |=> stop_active;
   endproperty
   a_stop_timer: assert property (p_stop_timer) // RULE_03
      else $error("stop timer not started");

   property p_start;
      s_start |=> s_running;
   endproperty
   a_start: assert property (p_start) // RULE_04
      else $error("start did not run oscillator with sample delay");

   property p_gate;
      (ce_i && stop_done && !clean_rd.univ &&
       q_reg.phase == tape_pkg::ST_STOP) |=>
         (q_reg.phase != tape_pkg::ST_RUN);
   endproperty
   a_gate: assert property (p_gate) // RULE_05
      else $error("oscillator started with gate closed");

   property p_idle_mark;
      (q_reg.phase == tape_pkg::ST_STOP && q_reg.sr == '1) |=>
         q_reg.sr[0];
   endproperty
   a_idle_mark: assert property (p_idle_mark) // RULE_06
      else $error("idle line left mark");

   property p_clear;
      (ce_i && clear_p && !sample_strobe) |=> (q_reg.sr == '0) &&
         line_drive_o;
   endproperty
   a_clear: assert property (p_clear) // RULE_10
      else $error("clear pulse did not give start space");

   property p_advance;
      (ce_i && adv_p && !sample_strobe) |=>
         (q_reg.sr == {1'b1, $past(q_reg.sr[8:1])});
   endproperty
   a_advance: assert property (p_advance) // RULE_11
      else $error("advance did not shift toward output");

   property p_invert;
      line_drive_o == !q_reg.sr[0];
   endproperty
   a_invert: assert property (p_invert) // RULE_14
      else $error("line drive not inverted output element");

   property p_rts;
      ce_i |=> (rts_o == ($past(q_reg.s2.high_speed) |
                          $past(q_reg.s2.motor)));
   endproperty
   a_rts: assert property (p_rts) // RULE_15
      else $error("request-to-send wrong");

   property p_pulse_count;
      (ce_i && tick && q_reg.pulse_cnt == tape_pkg::LAST_PULSE &&
       !pickup_evt) |=> (q_reg.phase == tape_pkg::ST_STOP);
   endproperty
   a_pulse_count: assert property (p_pulse_count) // RULE_18
      else $error("oscillator passed more than N+2 pulses");

endmodule : start_stop_tape_serializer
`default_nettype wire

// ---- sim/tape_reader_model.sv ----
// Purpose: tape reader stand-in driving mark, universal and pickup pins
// Assumes: one character per load call, contacts held through the frame
// Notes:   one level bounces briefly to exercise the contact filter
`timescale 1ns/1ps
`default_nettype none
module tape_reader_model (
   // clock
   input  wire logic       clk_sys_i,
   // reader pins
   output logic [7:0]      mark_o,
   output logic            univ_o,
   output logic            pickup_n_o
);
   initial begin
      mark_o     = 8'h00;
      univ_o     = 1'b0;
      pickup_n_o = 1'b1;
   end

   // contacts settle, one level bounces, then the character pulse
   task automatic load(input logic [7:0] code, input logic tape,
                       input int bnc, input int slow);
      @(posedge clk_sys_i);
      mark_o <= code;
      univ_o <= tape;
      repeat (500 + slow) @(posedge clk_sys_i);
      mark_o[bnc] <= ~code[bnc];
      repeat (60) @(posedge clk_sys_i);
      mark_o[bnc] <= code[bnc];
      repeat (4100) @(posedge clk_sys_i);
      pickup_n_o <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      pickup_n_o <= 1'b1;
   endtask : load
endmodule : tape_reader_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the start-stop tape serializer
// Assumes: shortened bit, half-bit, stop and power-on counts
// Notes:   frames are sampled mid-bit from the start space edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int BIT   = 40;
   localparam int HALF  = 20;
   localparam int STOP  = 40;
   localparam int LIMIT = 90000;

   logic       clk_sys_i      = 1'b0;
   logic       rst_i          = 1'b1;
   logic       ce_i           = 1'b1;
   logic       eight_level_i  = 1'b0;
   logic [7:0] level_used_i   = 8'hff;
   logic       motor_switch_i = 1'b0;
   logic       high_speed_i   = 1'b0;
   logic [7:0] mark_contact_i;
   logic       univ_contact_i;
   logic       pickup_n_i;
   logic       line_drive_o;
   logic       rts_o;
   logic       sample_o;
   logic       running_o;
   int         bad_count      = 0;
   int         num_checks     = 0;
   int         cyc            = 0;

   always #12.5 clk_sys_i = ~clk_sys_i;

   tape_reader_model u_reader (
      .clk_sys_i  (clk_sys_i),
      .mark_o     (mark_contact_i),
      .univ_o     (univ_contact_i),
      .pickup_n_o (pickup_n_i)
   );

   start_stop_tape_serializer #(
      .POR_CYC  (20),
      .BIT_CYC  (BIT),
      .HALF_CYC (HALF),
      .STOP_CYC (STOP)
   ) u_dut (
      .clk_sys_i      (clk_sys_i),
      .rst_i          (rst_i),
      .ce_i           (ce_i),
      .mark_contact_i (mark_contact_i),
      .univ_contact_i (univ_contact_i),
      .pickup_n_i     (pickup_n_i),
      .eight_level_i  (eight_level_i),
      .level_used_i   (level_used_i),
      .motor_switch_i (motor_switch_i),
      .high_speed_i   (high_speed_i),
      .line_drive_o   (line_drive_o),
      .rts_o          (rts_o),
      .sample_o       (sample_o),
      .running_o      (running_o)
   );

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask : check

   // code levels as they should appear, level 0 in bit 0
   function automatic logic [7:0] exp_levels(input logic [7:0] code,
                                             input logic eight,
                                             input logic [7:0] used);
      if (!eight) begin
         return (code & 8'h3e) | 8'hc1;
      end
      return (code & used) | (~used & 8'hc0);
   endfunction : exp_levels

   task automatic step;
      @(posedge clk_sys_i);
      #1;
   endtask : step

   // one character: start delay, frame bits, strobe and pulse count
   task automatic frame(input logic [7:0] code, input logic eight,
                        input logic [7:0] used, input int bnc,
                        input int slow);
      logic [7:0] lv;
      logic       e;
      int         n;
      int         run_n;
      @(posedge clk_sys_i);
      eight_level_i <= eight;
      level_used_i  <= used;
      lv = exp_levels(code, eight, used);
      u_reader.load(code, 1'b1, bnc, slow);
      n = 0;
      while (running_o !== 1'b1 && n < STOP + 20) begin
         step();
         n++;
      end
      check(n >= STOP - 2 && n <= STOP + 4, "start delay");
      step();
      check(line_drive_o === 1'b1, "no start space");
      run_n = 0;
      for (int c = 0; c < 10 * BIT; c++) begin
         if (c > 0) begin
            step();
         end
         run_n += int'(running_o === 1'b1);
         check(sample_o === (c == HALF - 1), "sample strobe");
         if (c % BIT == BIT / 2) begin
            n = c / BIT;
            e = (n == 0) ? 1'b1 : (n == 9) ? 1'b0 : ~lv[n-1];
            check(line_drive_o === e, "line bit");
         end
      end
      check(run_n >= 9 * BIT - 1 && run_n <= 9 * BIT + 1, "pulses");
      check(line_drive_o === 1'b0 && running_o === 1'b0, "stop");
   endtask : frame

   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == LIMIT) begin
         bad_count++;
         end_of_test();
      end
   end

   initial begin
      void'($urandom(59631));
      repeat (12) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (30) begin
         step();
         check(line_drive_o === 1'b0 && running_o === 1'b0, "por");
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys_i);
         motor_switch_i <= i[0];
         high_speed_i   <= i[1];
         repeat (5) step();
         check(rts_o === (i[0] | i[1]), "request to send");
      end
      // clock enable low must freeze the registered request-to-send
      @(posedge clk_sys_i);
      ce_i           <= 1'b0;
      motor_switch_i <= 1'b0;
      high_speed_i   <= 1'b0;
      repeat (6) step();
      check(rts_o === 1'b1, "clock enable freeze");
      @(posedge clk_sys_i);
      ce_i <= 1'b1;
      @(posedge clk_sys_i);
      motor_switch_i <= 1'b1;
      high_speed_i   <= 1'b0;
      frame(8'hff, 1'b0, 8'hff, 0, 0);
      frame(8'h00, 1'b0, 8'hff, 7, 0);
      frame(8'hff, 1'b1, 8'h00, 3, 0);
      frame(8'h00, 1'b1, 8'hff, 5, 0);
      frame(8'ha5, 1'b1, 8'h5a, 6, 0);
      repeat (4) begin
         frame(8'($urandom), 1'($urandom), 8'($urandom),
               int'($urandom % 8), int'($urandom % 200));
      end
      u_reader.load(8'h55, 1'b0, 2, 0);
      repeat (STOP + 4 * BIT) begin
         step();
         check(running_o === 1'b0 && line_drive_o === 1'b0, "no tape");
      end
      u_reader.load(8'h0f, 1'b1, 3, 0);
      repeat (STOP + 3 * BIT) @(posedge clk_sys_i);
      rst_i <= 1'b1;
      #1;
      check(line_drive_o === 1'b0 && running_o === 1'b0, "reset");
      repeat (3) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (30) begin
         step();
         check(line_drive_o === 1'b0 && sample_o === 1'b0, "post reset");
      end
      frame(8'h3c, 1'b0, 8'hff, 1, 10);
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
